//--- design/dus_pkg.sv
// shared constants and types for the converter update scheduler
package dus_pkg;
  localparam int unsigned CHANNELS = 2;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned BYTE_W = 8;

  // register map: byte offset = channel base + 4 * register offset
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_DATA_HIGH = 2'h1;
  localparam logic [1:0] REG_DATA_LOW = 2'h2;
  localparam logic [1:0] REG_LATCHED = 2'h3;

  // control register fields
  localparam int unsigned CTL_ON_BIT = 7;
  localparam int unsigned CTL_MODE_HI = 4;
  localparam int unsigned CTL_MODE_LO = 3;
  localparam int unsigned CTL_JUST_HI = 2;
  localparam int unsigned CTL_JUST_LO = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h9F;

  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [11:0] CODE_MIN = 12'h000;
  localparam logic [11:0] CODE_MAX = 12'hFFF;

  // update scheduling modes
  typedef enum logic [1:0] {
    MODE_ON_DEMAND = 2'h0,
    MODE_TIMER3 = 2'h1,
    MODE_TIMER4 = 2'h2,
    MODE_TIMER2 = 2'h3
  } dus_mode_type;

  // placements of the 12-bit word inside the 16-bit byte pair
  localparam logic [2:0] JUST_SHIFT0 = 3'h0;
  localparam logic [2:0] JUST_SHIFT1 = 3'h1;
  localparam logic [2:0] JUST_SHIFT2 = 3'h2;
  localparam logic [2:0] JUST_SHIFT3 = 3'h3;
  localparam logic [2:0] JUST_SHIFT4 = 3'h4;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // per-channel software-visible state
  typedef struct packed {
    logic on;
    dus_mode_type mode;
    logic [2:0] justify;
    logic [7:0] high;
    logic [7:0] low;
    logic [11:0] latched;
  } dus_chan_type;

  // timer overflow pulses
  typedef struct packed {
    logic t2;
    logic t3;
    logic t4;
  } dus_timers_type;
endpackage

//--- design/dus_dac_update_scheduler.sv
// ahb-lite register block scheduling the input latches of two 12-bit converters
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module dus_dac_update_scheduler
  import dus_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dus_timers_type timer_ovf,
  output logic [CHANNELS*CODE_W-1:0] conv_code,
  output logic [CHANNELS-1:0] conv_drive_en
);

  // address phase capture
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [ADDR_W-1:0] addr_reg;

  wire logic addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire logic word_size = (hsize == 3'h2);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
    end
    else if (hready)
    begin
      wr_pend_reg <= addr_phase && hwrite && word_size;
      rd_pend_reg <= addr_phase && !hwrite;
      addr_reg <= haddr[ADDR_W-1:0];
    end
  end

  // decode of the data-phase address; anything above the two channel windows is unmapped
  wire logic mapped = (addr_reg[ADDR_W-1:5] == '0) && (addr_reg[1:0] == 2'h0);
  wire logic sel_chan = addr_reg[4];
  wire logic [1:0] sel_reg = addr_reg[3:2];
  wire logic [7:0] wr_byte = hwdata[7:0];

  // every access completes with no wait states
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  logic [31:0] rd_word [CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      dus_chan_type st_reg;
      dus_chan_type st_next;

      wire logic hit = wr_pend_reg && mapped && (sel_chan == 1'(ch));
      wire logic wr_ctl = hit && (sel_reg == REG_CONTROL);
      wire logic wr_high = hit && (sel_reg == REG_DATA_HIGH);
      wire logic wr_low = hit && (sel_reg == REG_DATA_LOW);

      // byte pair as it will stand after this cycle's write
      wire logic [7:0] high_now = wr_high ? wr_byte : st_reg.high;
      wire logic [7:0] low_now = wr_low ? wr_byte : st_reg.low;
      wire logic [15:0] pair_now = {high_now, low_now};

      // placements: 000 right-aligned, 001..011 shifted up, 100 left-aligned
      wire logic [11:0] placed =
        (st_reg.justify == JUST_SHIFT1) ? pair_now[12:1] :
        (st_reg.justify == JUST_SHIFT2) ? pair_now[13:2] :
        (st_reg.justify == JUST_SHIFT3) ? pair_now[14:3] :
        (st_reg.justify == JUST_SHIFT4) ? pair_now[15:4] :
        pair_now[11:0];

      // the timer is chosen by the mode; on-demand ignores all timers
      wire logic timer_hit =
        (st_reg.mode == MODE_TIMER3) ? timer_ovf.t3 :
        (st_reg.mode == MODE_TIMER4) ? timer_ovf.t4 :
        (st_reg.mode == MODE_TIMER2) ? timer_ovf.t2 :
        1'b0;

      // a low-byte write never triggers; the high write does only in on-demand mode
      wire logic demand_hit = wr_high && (st_reg.mode == MODE_ON_DEMAND);
      wire logic update = demand_hit || timer_hit;

      always_comb
      begin
        st_next = st_reg;
        if (wr_ctl)
        begin
          st_next.on = wr_byte[CTL_ON_BIT];
          st_next.mode = dus_mode_type'(wr_byte[CTL_MODE_HI:CTL_MODE_LO]);
          st_next.justify = wr_byte[CTL_JUST_HI:CTL_JUST_LO];
        end
        st_next.high = high_now;
        st_next.low = low_now;
        // mode and justify in force are those before a same-cycle control write
        if (update)
        begin
          st_next.latched = placed;
        end
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          st_reg.on <= CTL_RESET[CTL_ON_BIT];
          st_reg.mode <= MODE_ON_DEMAND;
          st_reg.justify <= JUST_SHIFT0;
          st_reg.high <= DATA_RESET;
          st_reg.low <= DATA_RESET;
          st_reg.latched <= CODE_RESET;
        end
        else
        begin
          st_reg <= st_next;
        end
      end

      // bits 6:5 have no storage and read zero
      wire logic [7:0] ctl_read =
        {st_reg.on, 2'b00, st_reg.mode, st_reg.justify} & CTL_WRITE_MASK;

      assign rd_word[ch] =
        (sel_reg == REG_CONTROL) ? {24'h000000, ctl_read} :
        (sel_reg == REG_DATA_HIGH) ? {24'h000000, st_reg.high} :
        (sel_reg == REG_DATA_LOW) ? {24'h000000, st_reg.low} :
        {20'h00000, st_reg.latched};

      assign conv_code[ch*CODE_W +: CODE_W] = st_reg.latched;
      // output enable of the analog stage: low keeps the pin floating
      assign conv_drive_en[ch] = st_reg.on;
    end
  endgenerate

  // read data from register contents, selected during the data phase
  wire logic [31:0] rd_sel = sel_chan ? rd_word[1] : rd_word[0];
  assign hrdata = (rd_pend_reg && mapped) ? rd_sel : 32'h00000000;

endmodule
`default_nettype wire

//--- test/dus_props.sv
// port assertions for the converter update scheduler
`timescale 1ns/1ps
`default_nettype none
module dus_props
  import dus_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire dus_timers_type timer_ovf,
  input wire logic [CHANNELS*CODE_W-1:0] conv_code,
  input wire logic [CHANNELS-1:0] conv_drive_en
);
  logic wp, rp;
  logic [11:0] ra;
  wire logic ap = hsel && hready && htrans == HTRANS_NONSEQ;
  // the data-phase checks need the address that was taken
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp <= 1'b0;
      rp <= 1'b0;
      ra <= 12'h000;
    end
    else
    begin
      wp <= ap && hwrite;
      rp <= ap && !hwrite;
      ra <= ap ? haddr[11:0] : ra;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_CAUSE: assert property ($changed(conv_code) |-> $past(wp) || $past(timer_ovf) != 3'h0)
    else $error("code moved without trigger");
  AST_DRIVE: assert property ($changed(conv_drive_en) |-> $past(wp))
    else $error("drive moved without write");
  AST_ON: assert property ($past(wp) && $past(ra) == 12'h000 |-> conv_drive_en[0] == $past(hwdata[7]))
    else $error("drive differs from on bit");
  AST_CTL: assert property (rp && ra[3:0] == 4'h0 |-> hrdata[6:5] == 2'h0 && hrdata[31:8] == 24'h0)
    else $error("control reads unused bits");
  AST_LAT0: assert property (rp && ra == 12'h00C |-> hrdata == {20'h0, conv_code[11:0]})
    else $error("latched read ch0 wrong");
  AST_LAT1: assert property (rp && ra == 12'h01C |-> hrdata == {20'h0, conv_code[23:12]})
    else $error("latched read ch1 wrong");
  AST_LOW: assert property ($past(wp) && $past(ra) == 12'h008 && $past(timer_ovf) == 3'h0 |-> $stable(conv_code[11:0]))
    else $error("low write moved code");
  AST_IDLE: assert property (!rp |-> hrdata == 32'h0)
    else $error("read data outside read");
  AST_RESP: assert property (hreadyout == 1'b1 && hresp == HRESP_OKAY)
    else $error("bus response not ready and okay");
endmodule
`default_nettype wire

//--- test/dus_timer_src.sv
// timer overflow source: one-cycle pulses on request
`timescale 1ns/1ps
`default_nettype none
module dus_timer_src
  import dus_pkg::*;
(
  input wire logic hclk,
  input wire logic [2:0] fire,
  output dus_timers_type timer_ovf
);
  logic [2:0] q = 3'h0;
  // edge detect so a held request still gives a single overflow
  always_ff @(posedge hclk)
    q <= fire;
  assign timer_ovf = dus_timers_type'(fire & ~q);
endmodule
`default_nettype wire

//--- test/tb.sv
// bench: bus transfers and timer pulses against the scheduler
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dus_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [1:0] htrans = 2'h0, conv_drive_en;
  logic [2:0] fire = 3'h0, s;
  logic hreadyout, hresp;
  dus_timers_type timer_ovf;
  logic [23:0] conv_code, e;
  int bad_count, compares;
  dus_dac_update_scheduler uut (.*, .hsize(3'h2), .hready(hreadyout));
  dus_timer_src src (.hclk(hclk), .fire(fire), .timer_ovf(timer_ovf));
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task xf(input logic w, input logic [11:0] a, input logic [7:0] d);
    {hsel, hwrite, haddr, htrans} <= {1'b1, w, 20'h0, a, HTRANS_NONSEQ};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h0, d};
    // read data is taken at the edge that ends the data phase
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task cc;
    @(negedge hclk);
    chk("conv_code", {8'h0, e}, {8'h0, conv_code});
    // hand back on a rising edge so the next bus call starts right after it
    @(posedge hclk);
  endtask
  task pl(input logic [2:0] t);
    fire <= t;
    @(posedge hclk);
    fire <= 3'h0;
    @(posedge hclk);
    cc;
  endtask
  initial
  begin
    e = 24'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cc;
    xf(1'b1, 12'h000, 8'hFF);
    xf(1'b0, 12'h000, 8'h00);
    chk("control0", 32'h9F, v);
    chk("drive", 32'h1, {30'h0, conv_drive_en});
    xf(1'b1, 12'h000, 8'h80);
    xf(1'b1, 12'h008, 8'h34);
    cc;
    xf(1'b1, 12'h004, 8'h12);
    e[11:0] = 12'h234;
    cc;
    xf(1'b0, 12'h00C, 8'h00);
    chk("latched0", 32'h234, v);
    xf(1'b0, 12'h020, 8'h00);
    chk("unmapped", 32'h0, v);
    for (int j = 0; j < 8; j++)
    begin
      xf(1'b1, 12'h000, {5'h10, j[2:0]});
      xf(1'b1, 12'h008, 8'hCD);
      xf(1'b1, 12'h004, 8'hAB);
      v = 32'h0000ABCD >> (j < 5 ? j : 0);
      e[11:0] = v[11:0];
      cc;
    end
    xf(1'b1, 12'h000, 8'h84);
    xf(1'b1, 12'h008, 8'h00);
    xf(1'b1, 12'h004, 8'hFF);
    e[11:0] = 12'hFF0;
    cc;
    for (int m = 1; m < 4; m++)
    begin
      s = m == 1 ? 3'h2 : (m == 2 ? 3'h1 : 3'h4);
      xf(1'b1, 12'h010, {3'h4, m[1:0], 3'h0});
      xf(1'b1, 12'h018, 8'h5A);
      xf(1'b1, 12'h014, m[7:0]);
      cc;
      pl(~s);
      e[23:12] = {m[3:0], 8'h5A};
      pl(s);
    end
    xf(1'b0, 12'h01C, 8'h00);
    chk("latched1", 32'h35A, v);
    chk("drive", 32'h3, {30'h0, conv_drive_en});
    results;
  end
  initial
  begin
    #200000;
    bad_count++;
    results;
  end
endmodule
bind dus_dac_update_scheduler dus_props chk_u (.*);
`default_nettype wire
